// ===== hw/siom_pkg.sv
// Purpose: constants, register map and state encoding of the two-channel safety monitor
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   window figures are in milliseconds; cycle counts are derived from the clock period

package siom_pkg;

  // timebase
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 17;

  // windows in milliseconds, counted on the millisecond tick
  localparam int unsigned MS_W           = 11;
  localparam logic [10:0] ILK_WINDOW_MS  = 11'h0C8;  // 200 ms
  localparam logic [10:0] ILK_CLEAR_MS   = 11'h3E8;  // 1000 ms
  localparam logic [10:0] SWITCH_ON_MS   = 11'h064;  // 100 ms
  localparam logic [10:0] SYNC_SHORT_MS  = 11'h032;  // 50 ms
  localparam logic [10:0] SYNC_MID_MS    = 11'h064;  // 100 ms
  localparam logic [10:0] SYNC_LONG_MS   = 11'h1F4;  // 500 ms

  // register port
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_MASK   = 4'h8;
  localparam logic [3:0]  REG_STATE  = 4'hC;

  // control register fields
  localparam int unsigned CTRL_ANTIV   = 0;
  localparam int unsigned CTRL_SYNC_EN = 1;
  localparam int unsigned CTRL_SEL_LO  = 2;
  localparam int unsigned CTRL_ILK_EN  = 4;
  localparam int unsigned CTRL_AUTO    = 5;
  localparam int unsigned CTRL_RESTART = 6;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RW_MASK = 8'h3F;
  localparam logic [1:0]  SYNC_SEL_RESERVED = 2'h3;

  // status / mask bit positions
  localparam int unsigned EV_SYNC = 0;
  localparam int unsigned EV_ILK  = 1;
  localparam int unsigned EV_DISC = 2;
  localparam int unsigned EV_ERR  = 3;
  localparam int unsigned EV_ON   = 4;
  localparam int unsigned EV_OFF  = 5;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'h00;

  typedef enum logic [2:0] {
    SIOM_INIT = 3'h0,
    SIOM_DEEN = 3'h1,
    SIOM_EN   = 3'h3,
    SIOM_ERR  = 3'h2
  } siom_state_e;

  // synchronization time of the selected mechanism
  function automatic logic [10:0] siom_sync_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    siom_sync_limit = SYNC_SHORT_MS;
      2'h1:    siom_sync_limit = SYNC_MID_MS;
      2'h2:    siom_sync_limit = SYNC_LONG_MS;
      default: siom_sync_limit = 11'h000;
    endcase
  endfunction

endpackage

// ===== hw/siom_in_if.sv
// Purpose: carries synchronised contact levels and the millisecond tick
// Assumes: single clock domain
// Notes:   driven by the input stage, read by the monitor
`timescale 1ns/100ps

interface siom_in_if;
  logic normallyOpenChannel;
  logic normallyClosedChannel;
  logic startButton;
  logic msTick;

  modport src (
    output normallyOpenChannel,
    output normallyClosedChannel,
    output startButton,
    output msTick
  );
  modport dst (
    input  normallyOpenChannel,
    input  normallyClosedChannel,
    input  startButton,
    input  msTick
  );
endinterface

// ===== hw/siom_input_stage.sv
// Purpose: two-flop synchronisers for contacts and start button, millisecond tick divider
// Assumes: raw inputs may change at any time
// Notes:   first flop of each synchroniser feeds only the second
`timescale 1ns/100ps

module siom_input_stage #(
  parameter int unsigned TICK_CYCLES = siom_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic normallyOpenChannel,
  input  wire logic normallyClosedChannel,
  input  wire logic startButton,
  siom_in_if.src    syn
);

  typedef struct packed {
    logic [2:0]                       stage1;
    logic [2:0]                       stage2;
    logic [siom_pkg::DIV_W-1:0]       divCnt;
    logic                             tick;
  } siom_sync_s;

  siom_sync_s r;
  siom_sync_s next_r;
  logic [2:0] rawIn;

  assign rawIn = {startButton, normallyClosedChannel, normallyOpenChannel};

  always_comb begin
    next_r        = r;
    next_r.stage1 = rawIn;
    next_r.stage2 = r.stage1;
    next_r.tick   = 1'b0;
    if (r.divCnt == siom_pkg::DIV_W'(TICK_CYCLES - 1)) begin  // RULE_17
      next_r.divCnt = '0;
      next_r.tick   = 1'b1;
    end else begin
      next_r.divCnt = r.divCnt + siom_pkg::DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;  // RULE_17
    end
  end

  assign syn.normallyOpenChannel   = r.stage2[0];
  assign syn.normallyClosedChannel = r.stage2[1];
  assign syn.startButton           = r.stage2[2];
  assign syn.msTick                = r.tick;

endmodule

// ===== hw/siom_monitor.sv
// Purpose: two-channel safety input evaluation driving the safety-related output
// Assumes: 100 MHz clock, register port with read data one cycle after the strobe
// Notes:   output is high only in the energized run state; every other state is safe
//
// How it works
// RULE_01 - one channel active alone keeps the output off in the safe state
// RULE_02 - no energizing without the start condition, even with both channels active
// RULE_03 - start met and inputs active switches the output on within the activation delay
// RULE_04 - with synchronization, both channels must activate within the synchronization time
// RULE_05 - either channel deactivating while energized switches the output off at once
// RULE_06 - with interlock, both channels must drop within the window from the first drop
// RULE_07 - antivalent: open channel 0 and closed channel 1 means active
// RULE_08 - antivalent: open channel 1 and closed channel 0 means inactive, de-energized
// RULE_09 - antivalent: equal levels allowed only for the synchronization time, then alert
// RULE_10 - antivalent interpretation only when the configured function selects it
// RULE_11 - several synchronization times, chosen by the configured function
// RULE_12 - inactive inputs force de-energized; energizing only with active inputs
// RULE_13 - after reset, self-test then wait the switch-on delay before de-energized run; no self-test here, INIT checks cfgOk and waits the delay
// RULE_14 - any detected error enters an error state with the output off
// RULE_15 - interlock window is 200 ms; expiry raises alert and blocks energizing
// RULE_16 - interlock clears only after both channels stay inactive one second
// RULE_17 - inputs synchronised to the clock; all windows timed on a millisecond tick
`timescale 1ns/100ps

module siom_monitor #(
  parameter int unsigned TICK_CYCLES = siom_pkg::TICK_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          normallyOpenChannel,
  input  wire logic                          normallyClosedChannel,
  input  wire logic                          startButton,
  input  wire logic [siom_pkg::ADDR_W-1:0]   addr,
  input  wire logic [siom_pkg::DATA_W-1:0]   wrData,
  input  wire logic                          wrStb,
  input  wire logic                          rdStb,
  output logic      [siom_pkg::DATA_W-1:0]   rdData,
  output logic                               safetyOut,
  output logic                               irq
);

  typedef struct packed {
    siom_pkg::siom_state_e         st;
    logic [7:0]                    ctrl;
    logic [7:0]                    mask;
    logic [7:0]                    status;
    logic [7:0]                    rdData;
    logic                          safetyOut;
    logic                          irq;
    logic                          bothPrev;
    logic                          syncFail;
    logic [siom_pkg::MS_W-1:0]     syncCnt;
    logic                          ilkArmed;
    logic                          ilkLatched;
    logic                          dropA;
    logic [siom_pkg::MS_W-1:0]     ilkCnt;
    logic [siom_pkg::MS_W-1:0]     clrCnt;
    logic [siom_pkg::MS_W-1:0]     initCnt;
  } siom_regs_s;

  siom_in_if  syn ();

  siom_regs_s r;
  siom_regs_s next_r;

  logic       antiv;
  logic       syncEn;
  logic       ilkEn;
  logic       autoStart;
  logic [1:0] syncSel;
  logic [10:0] syncLimit;
  logic       cfgOk;
  logic       chA;
  logic       chB;
  logic       bothIn;
  logic       noneIn;
  logic       oneIn;
  logic       startOk;
  logic       ilkOk;
  logic       syncOk;
  logic       discFault;
  logic       ctrlWrite;
  logic       cfgWindow;
  logic       restartReq;
  logic [7:0] ev;
  logic [7:0] statusClr;

  siom_input_stage #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_input_stage (
    .clk                   (clk),
    .arst_n                (arst_n),
    .normallyOpenChannel   (normallyOpenChannel),
    .normallyClosedChannel (normallyClosedChannel),
    .startButton           (startButton),
    .syn                   (syn.src)
  );

  // configuration fields
  assign antiv     = r.ctrl[siom_pkg::CTRL_ANTIV];  // RULE_10
  assign syncEn    = r.ctrl[siom_pkg::CTRL_SYNC_EN];
  assign ilkEn     = r.ctrl[siom_pkg::CTRL_ILK_EN];
  assign autoStart = r.ctrl[siom_pkg::CTRL_AUTO];
  assign syncSel   = r.ctrl[siom_pkg::CTRL_SEL_LO +: 2];
  assign syncLimit = siom_pkg::siom_sync_limit(syncSel);  // RULE_11
  assign cfgOk     = (syncSel != siom_pkg::SYNC_SEL_RESERVED);

  // channel interpretation: the open channel is inverted only in antivalent mode
  assign chA    = antiv ? ~syn.normallyOpenChannel : syn.normallyOpenChannel;  // RULE_07
  assign chB    = syn.normallyClosedChannel;                                    // RULE_08
  assign bothIn = chA & chB;
  assign noneIn = ~chA & ~chB;
  assign oneIn  = chA ^ chB;

  // energizing permissions
  assign startOk = autoStart | syn.startButton;                  // RULE_02
  assign ilkOk   = ~ilkEn | (~r.ilkLatched & ~r.ilkArmed);        // RULE_15
  assign syncOk  = ~syncEn | ~r.syncFail;                         // RULE_04
  // equal levels in antivalent mode outlasting the synchronization time
  assign discFault = antiv & r.syncFail;                          // RULE_09

  // configuration only takes hold while the output cannot be energized
  assign cfgWindow  = (r.st == siom_pkg::SIOM_INIT) | (r.st == siom_pkg::SIOM_ERR);
  assign ctrlWrite  = wrStb & (addr == siom_pkg::REG_CTRL) & cfgWindow;
  assign restartReq = ctrlWrite & wrData[siom_pkg::CTRL_RESTART];
  assign statusClr  = (rdStb && addr == siom_pkg::REG_STATUS) ? r.status : 8'h00;

  always_comb begin
    next_r = r;
    ev     = 8'h00;

    next_r.bothPrev = bothIn;

    // synchronization time / antivalent equal-level timer, rearmed when both channels drop
    if (noneIn) begin
      next_r.syncFail = 1'b0;
      next_r.syncCnt  = '0;
    end else if (oneIn) begin
      if (syn.msTick && r.syncCnt != '1) begin  // RULE_17
        next_r.syncCnt = r.syncCnt + 11'h001;
      end
      if (r.syncCnt > syncLimit && !r.syncFail) begin  // RULE_04
        next_r.syncFail    = 1'b1;
        ev[siom_pkg::EV_SYNC] = syncEn;
        ev[siom_pkg::EV_DISC] = antiv;  // RULE_09
      end
    end

    // signal interlock monitoring
    if (!ilkEn) begin
      next_r.ilkArmed   = 1'b0;
      next_r.ilkLatched = 1'b0;
      next_r.ilkCnt     = '0;
      next_r.clrCnt     = '0;
    end else if (r.ilkLatched) begin
      if (noneIn) begin
        if (syn.msTick && r.clrCnt != '1) begin
          next_r.clrCnt = r.clrCnt + 11'h001;
        end
        if (r.clrCnt >= siom_pkg::ILK_CLEAR_MS) begin  // RULE_16
          next_r.ilkLatched = 1'b0;
          next_r.clrCnt     = '0;
        end
      end else begin
        next_r.clrCnt = '0;  // RULE_16
      end
    end else if (r.ilkArmed) begin
      if (noneIn) begin
        next_r.ilkArmed = 1'b0;  // RULE_06
      end else if (r.dropA ? chA : chB) begin
        // first channel came back before the second one dropped
        next_r.ilkArmed   = 1'b0;
        next_r.ilkLatched = 1'b1;
        next_r.clrCnt     = '0;
        ev[siom_pkg::EV_ILK] = 1'b1;  // RULE_06
      end else if (r.ilkCnt >= siom_pkg::ILK_WINDOW_MS) begin
        next_r.ilkArmed   = 1'b0;
        next_r.ilkLatched = 1'b1;
        next_r.clrCnt     = '0;
        ev[siom_pkg::EV_ILK] = 1'b1;  // RULE_15
      end else if (syn.msTick) begin
        next_r.ilkCnt = r.ilkCnt + 11'h001;
      end
    end else if (r.bothPrev && oneIn) begin
      next_r.ilkArmed = 1'b1;  // RULE_06
      next_r.dropA    = ~chA;
      next_r.ilkCnt   = '0;
    end else if (r.bothPrev && noneIn) begin
      next_r.ilkArmed = 1'b0;
    end

    // operating states
    case (r.st)
      siom_pkg::SIOM_INIT: begin
        if (!cfgOk) begin
          next_r.st = siom_pkg::SIOM_ERR;  // RULE_14
          ev[siom_pkg::EV_ERR] = 1'b1;
        end else if (r.initCnt >= siom_pkg::SWITCH_ON_MS) begin
          next_r.st = siom_pkg::SIOM_DEEN;  // RULE_13
        end else if (syn.msTick) begin
          next_r.initCnt = r.initCnt + 11'h001;
        end
      end
      siom_pkg::SIOM_DEEN: begin
        if (discFault) begin
          next_r.st = siom_pkg::SIOM_ERR;  // RULE_14
          ev[siom_pkg::EV_ERR] = 1'b1;
        end else if (bothIn && startOk && ilkOk && syncOk) begin
          next_r.st = siom_pkg::SIOM_EN;  // RULE_03
          ev[siom_pkg::EV_ON] = 1'b1;
        end
      end
      siom_pkg::SIOM_EN: begin
        if (!bothIn) begin
          next_r.st = siom_pkg::SIOM_DEEN;  // RULE_05
          ev[siom_pkg::EV_OFF] = 1'b1;
        end
      end
      siom_pkg::SIOM_ERR: begin
        if (restartReq) begin
          next_r.st      = siom_pkg::SIOM_INIT;
          next_r.initCnt = '0;
        end
      end
      default: begin
        next_r.st = siom_pkg::SIOM_ERR;  // RULE_14
        ev[siom_pkg::EV_ERR] = 1'b1;
      end
    endcase

    // a config change during init restarts the switch-on delay
    if (ctrlWrite) begin
      next_r.ctrl = wrData & siom_pkg::CTRL_RW_MASK;
      if (r.st == siom_pkg::SIOM_INIT) begin
        next_r.initCnt = '0;
      end
    end
    if (wrStb && addr == siom_pkg::REG_MASK) begin
      next_r.mask = wrData;
    end

    // set wins over the clear-on-read
    next_r.status = (r.status & ~statusClr) | ev;

    next_r.rdData = 8'h00;
    if (rdStb) begin
      case (addr)
        siom_pkg::REG_CTRL:   next_r.rdData = r.ctrl;
        siom_pkg::REG_STATUS: next_r.rdData = r.status;
        siom_pkg::REG_MASK:   next_r.rdData = r.mask;
        siom_pkg::REG_STATE:  next_r.rdData = {r.safetyOut, r.ilkLatched, r.syncFail, chB, chA, r.st};
        default:              next_r.rdData = 8'h00;
      endcase
    end

    // output follows the registered state; nothing but the energized state drives it
    next_r.safetyOut = (next_r.st == siom_pkg::SIOM_EN);  // RULE_01
    next_r.irq       = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r            <= '0;
      r.st         <= siom_pkg::SIOM_INIT;  // RULE_13
      r.ctrl       <= siom_pkg::CTRL_RESET;
      r.mask       <= siom_pkg::MASK_RESET;
      r.status     <= siom_pkg::STATUS_RESET;
    end else begin
      r <= next_r;  // RULE_12
    end
  end

  assign rdData    = r.rdData;
  assign safetyOut = r.safetyOut;
  assign irq       = r.irq;

endmodule

// ===== sim/siom_monitor_assertions.sv
// Purpose: port-level checks of the two-channel safety monitor
// Assumes: TICK_CYCLES equals the value given to the design
// Notes:   ctrl is unseen here, so checks lean on channel B and STATE reads
`timescale 1ns/100ps
module siom_monitor_assertions #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       normallyOpenChannel,
  input wire logic       normallyClosedChannel,
  input wire logic       startButton,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  input wire logic       safetyOut,
  input wire logic       irq
);
  localparam int unsigned INIT_CYC = 100 * TICK_CYCLES;
  logic [31:0] upCnt;
  logic        stRd;
  assign stRd = rdStb && (addr == siom_pkg::REG_STATE);
  // counts from reset release; the switch-on delay can only stretch it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) upCnt <= 32'h0;
    else if (upCnt < INIT_CYC) upCnt <= upCnt + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_bDrop;
    $fell(normallyClosedChannel) ##0 safetyOut;
  endsequence
  sequence s_stateRead;
    $past(stRd) ##0 $stable(safetyOut);
  endsequence
  a_b_low_off: assert property (!normallyClosedChannel [*4] |-> !safetyOut)
    else $error("output on with channel B inactive");
  // two synchroniser stages and the output register lie between the pin and the output, so look three samples back
  a_rise_needs_b: assert property ($rose(safetyOut) |-> $past(normallyClosedChannel, 3))
    else $error("output rose without channel B");
  a_drop_off: assert property (s_bDrop |-> ##[1:4] !safetyOut)
    else $error("output late to drop");
  a_sync_delay: assert property (s_bDrop |=> safetyOut)
    else $error("output reacted before synchroniser");
  a_init_quiet: assert property (upCnt < INIT_CYC |-> !safetyOut)
    else $error("output on during switch-on delay");
  a_init_code: assert property (upCnt < INIT_CYC && $past(stRd) |-> rdData[2:0] != 3'h3)
    else $error("energized state during switch-on delay");
  a_en_code: assert property ($past(stRd) && rdData[7] |-> rdData[2:0] == 3'h3)
    else $error("output on outside energized state");
  a_err_off: assert property ($past(stRd) && rdData[2:0] == 3'h2 |-> !rdData[7])
    else $error("output on in error state");
  a_state_out: assert property (s_stateRead ##0 $past(safetyOut, 2) == safetyOut
                                |-> rdData[7] == safetyOut)
    else $error("state output bit differs from output");
endmodule

// ===== sim/siom_contacts.sv
// Purpose: model of emergency stop contacts, start button and output contactor
// Assumes: commands change right after a rising edge
// Notes:   antivalent wiring inverts the open contact; a command of A=0,B=1 there gives equal levels
`timescale 1ns/100ps
module siom_contacts (
  input  wire logic clk,
  input  wire logic antiv,
  input  wire logic cmdA,
  input  wire logic cmdB,
  input  wire logic cmdStart,
  input  wire logic coilIn,
  output logic      normallyOpenChannel,
  output logic      normallyClosedChannel,
  output logic      startButton,
  output logic      contactorOn
);
  initial begin
    normallyOpenChannel   = 1'h0;
    normallyClosedChannel = 1'h0;
    startButton           = 1'h0;
    contactorOn           = 1'h0;
  end
  always @(posedge clk) begin
    normallyOpenChannel   <= antiv ? !cmdA : cmdA;
    normallyClosedChannel <= cmdB;
    startButton           <= cmdStart;
    contactorOn           <= coilIn;
  end
endmodule

// ===== sim/siom_monitor_tb_top.sv
// Purpose: self-checking bench of the safety monitor
// Assumes: TICK_CYCLES of 10, so one millisecond is 10 clocks
// Notes:   contacts reach the design through the contact model, one clock late
`timescale 1ns/100ps
module siom_monitor_tb_top;
  localparam int unsigned TK = 10;
  logic       clk, arst_n, noCh, ncCh, stBtn, wrStb, rdStb, safetyOut, irq;
  logic       antiv, cmdA, cmdB, cmdS, contactorOn;
  logic [3:0] addr;
  logic [7:0] wrData, rdData;
  int         nErrors, checked;
  siom_monitor #(.TICK_CYCLES(TK)) DUT (.clk(clk), .arst_n(arst_n), .normallyOpenChannel(noCh),
    .normallyClosedChannel(ncCh), .startButton(stBtn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .safetyOut(safetyOut), .irq(irq));
  siom_contacts uCon (.clk(clk), .antiv(antiv), .cmdA(cmdA), .cmdB(cmdB), .cmdStart(cmdS),
    .coilIn(safetyOut), .normallyOpenChannel(noCh), .normallyClosedChannel(ncCh), .startButton(stBtn),
    .contactorOn(contactorOn));
  task automatic printVerdict();
    $display("checked %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'h1;
    @(posedge clk);
    wrStb  <= 1'h0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'h1;
    @(posedge clk);
    rdStb <= 1'h0;
    #1 chk8(rdData & m, e);
  endtask
  task automatic drv(input logic a, input logic b, input logic s);
    @(posedge clk);
    cmdA <= a;
    cmdB <= b;
    cmdS <= s;
  endtask
  task automatic hold(input int ms);
    repeat (ms * TK) @(posedge clk);
  endtask
  task automatic waitOn(input logic e);
    int i;
    for (i = 0; i < 40 && contactorOn !== e; i++) @(posedge clk);
    chk1(contactorOn, e);
    if (i == 40) printVerdict();
  endtask
  task automatic waitDeen();
    int i;
    // polls STATE; each poll is a read strobe followed by its data cycle
    for (i = 0; i < 2000 && rdData[2:0] !== 3'h1; i++) begin
      @(posedge clk);
      addr  <= siom_pkg::REG_STATE;
      rdStb <= 1'h1;
      @(posedge clk);
      rdStb <= 1'h0;
      #1;
    end
    chk8({5'h00, rdData[2:0]}, 8'h01);
    if (i == 2000) printVerdict();
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    {arst_n, wrStb, rdStb, antiv, cmdA, cmdB, cmdS} = 7'h00;
    addr    = 4'h0;
    wrData  = 8'h00;
    nErrors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 16; i += 2) rdc(4'(i), 8'hFF, 8'h00);
    wr(siom_pkg::REG_STATE, 8'hFF);
    rdc(siom_pkg::REG_STATE, 8'hFF, 8'h00);
    wr(siom_pkg::REG_CTRL, 8'h12);
    wr(siom_pkg::REG_MASK, 8'h3F);
    rdc(siom_pkg::REG_CTRL, 8'hFF, 8'h12);
    waitDeen();
    $display("test reset done");
    drv(1'h1, 1'h0, 1'h0);
    hold(10);
    chk1(safetyOut, 1'h0);
    drv(1'h1, 1'h1, 1'h0);
    hold(10);
    chk1(safetyOut, 1'h0);
    drv(1'h1, 1'h1, 1'h1);
    waitOn(1'h1);
    chk1(irq, 1'h1);
    rdc(siom_pkg::REG_STATUS, 8'h11, 8'h10);
    chk1(irq, 1'h0);
    drv(1'h1, 1'h0, 1'h0);
    waitOn(1'h0);
    hold(20);
    drv(1'h0, 1'h0, 1'h0);
    hold(5);
    rdc(siom_pkg::REG_STATUS, 8'h22, 8'h20);
    $display("test energize done");
    drv(1'h1, 1'h0, 1'h0);
    hold(60);
    drv(1'h1, 1'h1, 1'h1);
    hold(10);
    chk1(safetyOut, 1'h0);
    rdc(siom_pkg::REG_STATUS, 8'h01, 8'h01);
    drv(1'h0, 1'h0, 1'h0);
    hold(5);
    $display("test sync done");
    drv(1'h1, 1'h1, 1'h1);
    waitOn(1'h1);
    drv(1'h1, 1'h0, 1'h1);
    hold(190);
    rdc(siom_pkg::REG_STATUS, 8'h02, 8'h00);
    hold(20);
    rdc(siom_pkg::REG_STATUS, 8'h02, 8'h02);
    drv(1'h0, 1'h0, 1'h1);
    hold(2);
    drv(1'h1, 1'h1, 1'h1);
    hold(10);
    chk1(safetyOut, 1'h0);
    drv(1'h0, 1'h0, 1'h1);
    hold(1010);
    drv(1'h1, 1'h1, 1'h1);
    waitOn(1'h1);
    drv(1'h0, 1'h0, 1'h0);
    $display("test interlock done");
    // second reset in mid-run: ctrl is only writable in the init and error states
    @(posedge clk);
    arst_n <= 1'h0;
    antiv  <= 1'h1;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    wr(siom_pkg::REG_CTRL, 8'h27);
    wr(siom_pkg::REG_MASK, 8'h3F);
    waitDeen();
    drv(1'h1, 1'h1, 1'h0);
    waitOn(1'h1);
    drv(1'h0, 1'h0, 1'h0);
    waitOn(1'h0);
    drv(1'h0, 1'h1, 1'h0);
    hold(60);
    rdc(siom_pkg::REG_STATUS, 8'h04, 8'h00);
    hold(60);
    rdc(siom_pkg::REG_STATUS, 8'h0C, 8'h0C);
    rdc(siom_pkg::REG_STATE, 8'h87, 8'h02);
    wr(siom_pkg::REG_CTRL, 8'h40);
    rdc(siom_pkg::REG_STATE, 8'h07, 8'h00);
    $display("test antivalent done");
    // reserved synchronization select is refused at init
    wr(siom_pkg::REG_CTRL, 8'h0C);
    rdc(siom_pkg::REG_STATE, 8'h07, 8'h02);
    rdc(siom_pkg::REG_STATUS, 8'h08, 8'h08);
    // longest synchronization time: 300 ms of equal levels is tolerated, 600 ms is not
    drv(1'h0, 1'h0, 1'h0);
    wr(siom_pkg::REG_CTRL, 8'h4B);
    waitDeen();
    drv(1'h0, 1'h1, 1'h0);
    hold(300);
    rdc(siom_pkg::REG_STATUS, 8'h04, 8'h00);
    hold(300);
    rdc(siom_pkg::REG_STATUS, 8'h04, 8'h04);
    $display("test config done");
    printVerdict();
  end
endmodule
bind siom_monitor siom_monitor_assertions #(.TICK_CYCLES(TICK_CYCLES)) uChk (.clk(clk), .arst_n(arst_n),
  .normallyOpenChannel(normallyOpenChannel), .normallyClosedChannel(normallyClosedChannel),
  .startButton(startButton), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
  .rdData(rdData), .safetyOut(safetyOut), .irq(irq));
